// File: rtl/tbso_defs.svh
// Purpose: constants for the tuning bar serial overlay
// Assumes: 10 MHz main clock
// Notes:   counts are in main clock cycles
`ifndef TBSO_DEFS_SVH
`define TBSO_DEFS_SVH
`define TBSO_FRAME_BITS      15
`define TBSO_BAND_LSB        0
`define TBSO_PROG_LSB        2
`define TBSO_VOLT_LSB        6
`define TBSO_SRCH_BIT        14
`define TBSO_IDLE_CYC        16'h0040
`define TBSO_VDELAY_CYC      16'h0100
`define TBSO_HDELAY_CYC      8'h20
`define TBSO_LINES           8'h0B
`define TBSO_BAR_STEP_CYC    8'h02
`endif

// File: rtl/tbso_pkg.sv
// Purpose: shared types for the tuning bar serial overlay
// Assumes: field positions from tbso_defs.svh
// Notes:   none
package tbso_pkg;
   typedef struct packed {
      logic       search;
      logic [7:0] volt;
      logic [3:0] prog;
      logic [1:0] band;
   } tbso_frame_t;
   typedef enum logic [1:0] {
      TBSO_IDLE  = 2'b00,
      TBSO_VWAIT = 2'b01,
      TBSO_SHOW  = 2'b10
   } tbso_vstate_t;
endpackage : tbso_pkg

// File: rtl/tbso_top.sv
// Purpose: serial frame receiver and overlay timing for a tuning bar
// Assumes: burst clock arrives unrelated to clk_in; syncs are pins
// Notes:   video outputs are open drain, enable high pulls low
`timescale 1ns/1ns
`default_nettype none
`include "tbso_defs.svh"

// Summary of operation
// - shift data on each burst clock pulse
// - latch frame only after burst ends
// - display keeps old values during shifting
// - decode band, program, voltage, search flag
// - detect end of clock activity for latch
// - video white means output released
// - second video output is the inverse
// - frame timing starts on sync falling edge
// - one-shot delay then display enabled
// - wait 32 clocks after line sync edge
// - blank whole line while overlay is shown
module tbso_top #(
   parameter logic [15:0] IDLE_CYC   = `TBSO_IDLE_CYC,
   parameter logic [15:0] VDELAY_CYC = `TBSO_VDELAY_CYC,
   parameter bit          MSB_FIRST  = 1'b0
) (
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic              burst_clk_in,
   input  wire logic              data_in,
   input  wire logic              vsync_in,
   input  wire logic              hsync_in,
   input  wire logic              show_in,
   output logic                   video_oe_out,
   output logic                   video_n_oe_out,
   output logic                   blank_oe_out,
   output tbso_pkg::tbso_frame_t  frame_out
);

   // link domain: shift register and toggle per bit
   logic [14:0] shift_reg;
   logic [14:0] shift_next;
   logic        tog_reg;
   logic        tog_next;

   always_comb begin
      if (MSB_FIRST) begin
         shift_next = {shift_reg[13:0], data_in};
      end else begin
         shift_next = {data_in, shift_reg[14:1]};
      end
      tog_next = ~tog_reg;
   end

   // no reset on the shift register: the burst clock stops between frames
   always_ff @(posedge burst_clk_in) begin
      shift_reg <= shift_next;
   end

   // toggle cleared by rst_in directly; the link is quiet while reset stands,
   // so the release cannot meet a burst clock edge
   always_ff @(posedge burst_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tog_reg <= 1'b0;
      end else begin
         tog_reg <= tog_next;
      end
   end

   // main domain synchronisers
   // limitation: only the toggle parity crosses, so a burst of an even pulse
   // count inside one clock cycle would go unseen; frames carry 15 pulses
   logic [1:0] tog_s_reg, vs_s_reg, hs_s_reg, sh_s_reg;
   logic       tog_d_reg, vs_d_reg, hs_d_reg;
   always_ff @(posedge clk_in) begin
      tog_s_reg <= {tog_s_reg[0], tog_reg};
      vs_s_reg  <= {vs_s_reg[0], vsync_in};
      hs_s_reg  <= {hs_s_reg[0], hsync_in};
      sh_s_reg  <= {sh_s_reg[0], show_in};
      tog_d_reg <= tog_s_reg[1];
      vs_d_reg  <= vs_s_reg[1];
      hs_d_reg  <= hs_s_reg[1];
   end

   logic bit_seen;
   logic vs_fall;
   logic hs_fall;
   assign bit_seen = tog_s_reg[1] ^ tog_d_reg;
   assign vs_fall  = vs_d_reg & ~vs_s_reg[1];
   assign hs_fall  = hs_d_reg & ~hs_s_reg[1];

   // idle counter and frame latch
   logic [15:0]           idle_reg, idle_next;
   logic                  armed_reg, armed_next;
   logic [14:0]           cap_reg, cap_next;
   tbso_pkg::tbso_frame_t frame_reg, frame_next;

   always_comb begin
      idle_next  = idle_reg;
      armed_next = armed_reg;
      cap_next   = cap_reg;
      frame_next = frame_reg; // held while bits arrive
      if (bit_seen) begin
         idle_next  = 16'h0000;
         armed_next = 1'b1;
      end else if (armed_reg) begin
         if (idle_reg == IDLE_CYC - 16'h0001) begin
            armed_next = 1'b0;
            // shift_reg is static now; quiet long past the last edge
            cap_next   = shift_reg;
         end else begin
            idle_next = idle_reg + 16'h0001;
         end
      end
      // idle count parks at its end value after capture, so the decoder
      // reloads the same word until the next bit restarts the count
      if (!armed_reg && armed_next == 1'b0 && idle_reg == IDLE_CYC - 16'h0001) begin
         frame_next.band   = cap_reg[`TBSO_BAND_LSB +: 2];
         frame_next.prog   = cap_reg[`TBSO_PROG_LSB +: 4];
         frame_next.volt   = cap_reg[`TBSO_VOLT_LSB +: 8];
         frame_next.search = cap_reg[`TBSO_SRCH_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         idle_reg  <= 16'h0000;
         armed_reg <= 1'b0;
         cap_reg   <= 15'h0000;
         frame_reg <= '0;
      end else begin
         idle_reg  <= idle_next;
         armed_reg <= armed_next;
         cap_reg   <= cap_next;
         frame_reg <= frame_next;
      end
   end

   // vertical one-shot and line counting
   tbso_pkg::tbso_vstate_t vst_reg, vst_next;
   logic [15:0] vcnt_reg, vcnt_next;
   logic [7:0]  lines_reg, lines_next;
   logic [7:0]  hcnt_reg, hcnt_next;
   logic        line_on_reg, line_on_next;

   always_comb begin
      vst_next     = vst_reg;
      vcnt_next    = vcnt_reg;
      lines_next   = lines_reg;
      hcnt_next    = hcnt_reg;
      line_on_next = line_on_reg;
      case (vst_reg)
         tbso_pkg::TBSO_IDLE: begin
            line_on_next = 1'b0;
         end
         tbso_pkg::TBSO_VWAIT: begin
            if (vcnt_reg == VDELAY_CYC) begin
               vst_next   = tbso_pkg::TBSO_SHOW;
               lines_next = 8'h00;
            end else begin
               vcnt_next = vcnt_reg + 16'h0001;
            end
         end
         tbso_pkg::TBSO_SHOW: begin
            if (hs_fall) begin
               if (lines_reg == `TBSO_LINES) begin
                  vst_next     = tbso_pkg::TBSO_IDLE;
                  line_on_next = 1'b0;
               end else begin
                  lines_next   = lines_reg + 8'h01;
                  line_on_next = 1'b1; // whole line
                  hcnt_next    = 8'h00;
               end
            end else if (hcnt_reg != 8'hFF) begin // saturate, no wrap onto the bar
               hcnt_next = hcnt_reg + 8'h01;
            end
         end
         default: begin
            vst_next = tbso_pkg::TBSO_IDLE;
         end
      endcase
      if (vs_fall) begin // restart on every frame
         vst_next     = tbso_pkg::TBSO_VWAIT;
         vcnt_next    = 16'h0000;
         line_on_next = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         vst_reg     <= tbso_pkg::TBSO_IDLE;
         vcnt_reg    <= 16'h0000;
         lines_reg   <= 8'h00;
         hcnt_reg    <= 8'hFF;
         line_on_reg <= 1'b0;
      end else begin
         vst_reg     <= vst_next;
         vcnt_reg    <= vcnt_next;
         lines_reg   <= lines_next;
         hcnt_reg    <= hcnt_next;
         line_on_reg <= line_on_next;
      end
   end

   // horizontal bar: starts 32 clocks in, length set by voltage
   logic       enable;
   logic       white;
   logic [7:0] bar_pos;
   assign enable  = sh_s_reg[1] | frame_reg.search;
   assign bar_pos = hcnt_reg - `TBSO_HDELAY_CYC;
   assign white   = enable & line_on_reg &
                    (hcnt_reg >= `TBSO_HDELAY_CYC) &
                    (bar_pos < {1'b0, frame_reg.volt[7:1]});

   // outputs registered; white releases the pin
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         video_oe_out   <= 1'b1;
         video_n_oe_out <= 1'b0;
         blank_oe_out   <= 1'b1;
         frame_out      <= '0;
      end else begin
         video_oe_out   <= ~white;
         video_n_oe_out <= white;
         blank_oe_out   <= ~(enable & line_on_reg); // released = blank
         frame_out      <= frame_reg;
      end
   end

   // checks
   inverse_pair_a: assert property (@(posedge clk_in) disable iff (rst_in)
      video_oe_out != video_n_oe_out) else $error("video outputs not inverse");
   white_release_a: assert property (@(posedge clk_in) disable iff (rst_in)
      white |=> !video_oe_out) else $error("white did not release video");
   hold_during_a: assert property (@(posedge clk_in) disable iff (rst_in)
      bit_seen |=> $stable(frame_reg)) else $error("frame changed mid burst");
   latch_after_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(cap_reg) |-> !armed_reg && $past(armed_reg)) else $error("early latch");
   idle_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
      armed_reg |-> idle_reg < IDLE_CYC) else $error("idle counter overrun");
   vsync_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
      vs_fall |=> vst_reg == tbso_pkg::TBSO_VWAIT && vcnt_reg == 16'h0000)
      else $error("frame timing not started");
   vdelay_a: assert property (@(posedge clk_in) disable iff (rst_in)
      vst_reg == tbso_pkg::TBSO_VWAIT |-> !line_on_reg) else $error("shown before delay");
   hdelay_a: assert property (@(posedge clk_in) disable iff (rst_in)
      white |-> hcnt_reg >= 8'h20) else $error("bar before 32 clocks");

   // latch side: a seen bit arms the idle count from zero
   armed_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
      bit_seen |=> armed_reg && idle_reg == 16'h0000)
      else $error("idle count not restarted");
   // capture stands still until the full quiet time has passed
   cap_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !(armed_reg && idle_reg == IDLE_CYC - 16'h0001) |=> $stable(cap_reg))
      else $error("capture moved before quiet time");
   // the decoder only ever takes what was captured
   latch_fields_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(frame_reg) |-> frame_reg == $past(cap_reg))
      else $error("frame fields do not match capture");
   // a shifted word never reaches the display while the count is armed
   no_early_frame_a: assert property (@(posedge clk_in) disable iff (rst_in)
      armed_reg |=> $stable(frame_reg)) else $error("frame latched while armed");

   // display side: a frame sync closes any open line
   vsync_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
      vs_fall |=> !line_on_reg) else $error("line open after frame sync");
   // vertical one-shot counts one step a cycle, then opens the display
   vwait_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
      vst_reg == tbso_pkg::TBSO_VWAIT && vcnt_reg != VDELAY_CYC && !vs_fall
      |=> vst_reg == tbso_pkg::TBSO_VWAIT && vcnt_reg == $past(vcnt_reg) + 16'h0001)
      else $error("vertical delay not counting");
   show_entry_a: assert property (@(posedge clk_in) disable iff (rst_in)
      vst_reg == tbso_pkg::TBSO_VWAIT && vcnt_reg == VDELAY_CYC && !vs_fall
      |=> vst_reg == tbso_pkg::TBSO_SHOW && lines_reg == 8'h00)
      else $error("display not opened after delay");
   // a line sync fall opens a line and restarts the horizontal count
   line_open_a: assert property (@(posedge clk_in) disable iff (rst_in)
      vst_reg == tbso_pkg::TBSO_SHOW && hs_fall && lines_reg != `TBSO_LINES && !vs_fall
      |=> line_on_reg && hcnt_reg == 8'h00)
      else $error("line not opened on sync");
   // an open line stays open for its whole length
   line_keep_a: assert property (@(posedge clk_in) disable iff (rst_in)
      line_on_reg && vst_reg == tbso_pkg::TBSO_SHOW && !hs_fall && !vs_fall
      |=> line_on_reg) else $error("line dropped mid line");
   // never more lines than the overlay height
   line_limit_a: assert property (@(posedge clk_in) disable iff (rst_in)
      lines_reg <= `TBSO_LINES) else $error("line count overrun");

   // output side: blanking follows the shown lines and nothing else
   blank_line_a: assert property (@(posedge clk_in) disable iff (rst_in)
      enable && line_on_reg |=> !blank_oe_out) else $error("shown line not blanked");
   blank_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
      vst_reg == tbso_pkg::TBSO_IDLE |=> blank_oe_out) else $error("blank outside display");
   // dark whenever the bar is not drawn
   video_dark_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !white |=> video_oe_out) else $error("video released without bar");

endmodule : tbso_top
`default_nettype wire

// File: verification/tbso_pmc_model.sv
// Purpose: sender model of the program memory controller bursts
// Assumes: word bit 0 goes out first
// Notes:   slow_in leaves one quiet link cycle between pulses
`timescale 1ns/1ns
`default_nettype none
module tbso_pmc_model (
   input  wire logic        link_clk_in,
   input  wire logic        go_in,
   input  wire logic        slow_in,
   input  wire logic [14:0] word_in,
   output logic             burst_clk_out,
   output logic             data_out,
   output var logic         done_out
);
   logic en_reg = 1'b0;
   // gate moves on falling link edge, so no glitch; clock still between frames
   assign burst_clk_out = en_reg & link_clk_in;
   initial data_out = 1'b0;
   initial done_out = 1'b0;
   // one burst of 15 pulses per request
   always @(negedge link_clk_in) begin
      if (go_in && !done_out) begin
         for (int i = 0; i < 15; i++) begin
            data_out = word_in[i];
            en_reg = 1'b1;
            @(negedge link_clk_in);
            en_reg = 1'b0;
            if (slow_in) begin
               data_out = ~data_out; // hold time over, line no longer valid
               @(negedge link_clk_in);
            end
         end
         if (!slow_in) data_out = ~data_out;
         done_out = 1'b1;
      end else if (!go_in) begin
         done_out = 1'b0;
      end
   end
endmodule : tbso_pmc_model
`default_nettype wire

// File: verification/tbso_top_tb.sv
// Purpose: self-checking bench for the tuning bar serial overlay
// Assumes: idle count 8, vertical delay 10
// Notes:   link clock 6 ns, free of the main clock phase
`timescale 1ns/1ns
`default_nettype none
module tbso_top_tb;
   logic clk_in = 0, rst_in = 0, link_clk = 0, go = 0, slow = 0;
   logic vsync_in = 0, hsync_in = 0, show_in = 0;
   logic [14:0] word = 15'h0000;
   logic burst_clk, data, done, video_oe_out, video_n_oe_out, blank_oe_out;
   tbso_pkg::tbso_frame_t frame_out;
   int n_errors = 0, comparisons = 0;
   initial forever #50 clk_in = ~clk_in;
   initial begin
      #1;
      forever #3 link_clk = ~link_clk;
   end
   tbso_top #(.IDLE_CYC(16'h0008), .VDELAY_CYC(16'h000A)) dut (.clk_in(clk_in),
      .rst_in(rst_in), .burst_clk_in(burst_clk), .data_in(data), .vsync_in(vsync_in),
      .hsync_in(hsync_in), .show_in(show_in), .video_oe_out(video_oe_out),
      .video_n_oe_out(video_n_oe_out), .blank_oe_out(blank_oe_out), .frame_out(frame_out));
   tbso_pmc_model pmc (.link_clk_in(link_clk), .go_in(go), .slow_in(slow), .word_in(word),
      .burst_clk_out(burst_clk), .data_out(data), .done_out(done));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   // inverse output watched on every cycle out of reset
   always @(negedge clk_in) if (!rst_in) check(video_n_oe_out, {15'h0000, ~video_oe_out});
   // one frame: old value stands at burst end and 4 cycles later, then the new word
   task automatic frame_test(input logic [14:0] w, input logic s, input logic [14:0] old);
      int i;
      word = w;
      slow = s;
      go = 1'b1;
      for (i = 0; i < 50 && done !== 1'b1; i++) @(posedge clk_in);
      if (done !== 1'b1) begin
         n_errors++;
         results();
      end
      check(frame_out, old);
      #5 go = 1'b0;
      repeat (4) @(posedge clk_in);
      #5 check(frame_out, old);
      repeat (12) @(posedge clk_in);
      #5 check(frame_out, w);
   endtask : frame_test
   // frame sync, then one displayed line with a bar of volt/2 cycles
   task automatic display_test();
      int early = 0, white = 0, blk = 0;
      show_in = 1'b1;
      vsync_in = 1'b1;
      repeat (3) @(posedge clk_in);
      #5 vsync_in = 1'b0;
      repeat (5) @(posedge clk_in);
      #5 check(blank_oe_out, 1'b1);
      repeat (20) @(posedge clk_in);
      #5 hsync_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #5 hsync_in = 1'b0;
      for (int i = 0; i < 120; i++) begin
         @(posedge clk_in);
         #5;
         if (video_oe_out === 1'b0) white++;
         if (video_oe_out === 1'b0 && i < 32) early++;
         if (blank_oe_out === 1'b0) blk++;
      end
      check(early, 0);
      check(white, 10);
      check(blk != 0, 1'b1);
   endtask : display_test
   initial begin
      #1 rst_in = 1'b1;
      repeat (6) @(posedge clk_in);
      #5 rst_in = 1'b0;
      check(frame_out, 0);
      check(video_oe_out, 1'b1);
      check(blank_oe_out, 1'b1);
      frame_test(15'h6B93, 1'b1, 15'h0000);
      frame_test(15'h050D, 1'b0, 15'h6B93);
      check(frame_out.volt, 8'h14);
      display_test();
      results();
   end
endmodule : tbso_top_tb
`default_nettype wire
